// ==== hdl/fsot_toggler.v ====
// How it works
// - One-shot toggles happen only in the field right after the trigger
// - At most four toggle positions per output in a field
// - Protocol 1 is one-shot; trigger bits sit at 0x70 bits 13 to 6
// - Rewriting the trigger each field repeats one-shot toggles every field
// - Protocol 5 follows the first field counter, 6 the second
// - Under 5 or 6, no field-1 toggle means all toggles ignored
// - Toggle positions may be written any time without disturbing outputs
// - Repeat variant keeps cycling the pattern with the field counter
// - Delayed variant postpones toggles by a counted number of fields
// - One logic table per output pair 1-2, 3-4, 5-6, 7-8
// - Each pin shows either table result or its raw toggle signal
// - Each 4-bit table realises any function; pair 1-2 at 0x7B bits 11:8
// - XOR 0110, NAND 1110, AND 0001, OR 0111 over the four input combinations
// - Launch bits clear at each field start; one field between writes
// - Starting polarity loads only while protocol is 0
// - A toggle position is field, line and pixel, 13 bits each
// - Table codes 6 XOR, 7 NAND, 8 AND, E OR
`timescale 1ns/1ps
`default_nettype none
`include "fsot_map.vh"

module fsot_toggler #(
    parameter OUTPUTS = 8,
    parameter TOGGLES = 4,
    parameter VAL_W   = 13
) (
    // Clock and reset
    input  wire              clk_sys_i,
    input  wire              reset_i,
    // Register port
    input  wire [7:0]        reg_addr_i,
    input  wire [31:0]       reg_wdata_i,
    input  wire              reg_wr_i,
    input  wire              reg_rd_i,
    output reg  [31:0]       reg_rdata_o,
    // Timing from the raster counters
    input  wire              field_sync_pulse_i,
    input  wire              line_sync_pulse_i,
    // Output pins
    output reg  [OUTPUTS-1:0] aux_output_pin_o
);

    localparam WORDS = OUTPUTS * 6;
    localparam POS_W = 2 * VAL_W;

    // Register file
    reg  [1:0]          launch_reg;
    reg  [7:0]          one_shot_field_trigger_reg;
    reg  [31:0]         field_max_reg;
    reg  [31:0]         field_dly_reg;
    reg  [23:0]         output_protocol_select_reg;
    reg  [7:0]          polarity_reg;
    reg  [23:0]         lut_cfg_reg;

    // Raster position
    reg  [VAL_W-1:0]    pixel_cnt_reg;
    reg  [VAL_W-1:0]    line_cnt_reg;

    // Field counters
    reg  [VAL_W-1:0]    fcnt_reg [0:1];
    reg  [VAL_W-1:0]    fdly_reg [0:1];
    reg  [1:0]          frun_reg;

    // Per-output state
    reg  [OUTPUTS-1:0]  aux_toggle_signal_reg;
    reg  [OUTPUTS-1:0]  one_shot_active_reg;
    reg  [OUTPUTS-1:0]  one_shot_ready_reg;

    wire [WORDS*POS_W-1:0] pos_words;
    wire [OUTPUTS-1:0]     hit;
    wire [OUTPUTS-1:0]     pin_level;
    wire                   field_start;
    wire                   pos_wr;

    // One decode for write and read
    function in_pos_window;
        input [7:0] addr;
        begin
            in_pos_window = addr >= `FSOT_ADDR_POS_FIRST && addr <= `FSOT_ADDR_POS_LAST;
        end
    endfunction

    // Word index in the position window
    function [5:0] pos_index;
        input [7:0] addr;
        reg   [7:0] off;
        begin
            off       = addr - `FSOT_ADDR_POS_FIRST;
            pos_index = off[5:0];
        end
    endfunction

    assign field_start = field_sync_pulse_i;
    assign pos_wr      = reg_wr_i && in_pos_window(reg_addr_i);

    // Protocol code of one output
    function [2:0] proto_of;
        input [23:0] sel;
        input integer idx;
        begin
            proto_of = sel[idx*3 +: 3];
        end
    endfunction

    // Position storage
    fsot_pos_mem #(
        .WORDS     (WORDS),
        .WIDTH     (POS_W)
    ) u_pos_mem (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .wr_i      (pos_wr),
        .wr_idx_i  (pos_index(reg_addr_i)),
        .wr_data_i (reg_wdata_i[POS_W-1:0]),
        .words_o   (pos_words)
    );

    // Register writes; hardware clear at field start loses to a write
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            launch_reg                 <= 2'h0;
            one_shot_field_trigger_reg <= 8'h00;
            field_max_reg              <= `FSOT_RST_WORD;
            field_dly_reg              <= `FSOT_RST_WORD;
            output_protocol_select_reg <= 24'h000000;
            polarity_reg               <= 8'h00;
            lut_cfg_reg                <= 24'h000000;
        end else begin
            if (field_start) begin
                launch_reg                 <= 2'h0;
                one_shot_field_trigger_reg <= 8'h00;
            end
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `FSOT_ADDR_LAUNCH: begin
                        launch_reg                 <= reg_wdata_i[1:0];
                        one_shot_field_trigger_reg <=
                            reg_wdata_i[`FSOT_TRIG_MSB:`FSOT_TRIG_LSB];
                    end
                    `FSOT_ADDR_FIELD_MAX: field_max_reg <= reg_wdata_i;
                    `FSOT_ADDR_FIELD_DLY: field_dly_reg <= reg_wdata_i;
                    `FSOT_ADDR_PROTOCOL:  output_protocol_select_reg <= reg_wdata_i[23:0];
                    `FSOT_ADDR_POLARITY:  polarity_reg <= reg_wdata_i[7:0];
                    `FSOT_ADDR_LUT_CFG:   lut_cfg_reg <= reg_wdata_i[23:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Pixel and line position within the field
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            pixel_cnt_reg <= 13'h0000;
            line_cnt_reg  <= 13'h0000;
        end else if (field_start) begin
            pixel_cnt_reg <= 13'h0000;
            line_cnt_reg  <= 13'h0000;
        end else if (line_sync_pulse_i) begin
            pixel_cnt_reg <= 13'h0000;
            line_cnt_reg  <= line_cnt_reg + 13'h0001;
        end else begin
            pixel_cnt_reg <= pixel_cnt_reg + 13'h0001;
        end
    end

    // First and second field counters; 0 while idle or still delaying
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_fcnt
            wire [VAL_W-1:0] max_fields;
            wire [VAL_W-1:0] dly_fields;
            wire             repeat_on;

            assign max_fields = field_max_reg[c*VAL_W +: VAL_W];
            assign dly_fields = field_dly_reg[c*VAL_W +: VAL_W];
            assign repeat_on  = field_max_reg[`FSOT_REPEAT_FIRST + c];

            always @(posedge clk_sys_i) begin
                if (reset_i) begin
                    fcnt_reg[c] <= 13'h0000;
                    fdly_reg[c] <= 13'h0000;
                    frun_reg[c] <= 1'b0;
                end else if (field_start) begin
                    // A launch restarts even a running counter
                    if (launch_reg[c]) begin
                        frun_reg[c] <= 1'b1;
                        fdly_reg[c] <= dly_fields;
                        fcnt_reg[c] <= (dly_fields == 13'h0000) ? 13'h0001 : 13'h0000;
                    end else if (frun_reg[c]) begin
                        if (fdly_reg[c] != 13'h0000) begin
                            fdly_reg[c] <= fdly_reg[c] - 13'h0001;
                            if (fdly_reg[c] == 13'h0001) begin
                                fcnt_reg[c] <= 13'h0001;
                            end
                        end else if (fcnt_reg[c] >= max_fields) begin
                            if (repeat_on) begin
                                fcnt_reg[c] <= 13'h0001;
                            end else begin
                                fcnt_reg[c] <= 13'h0000;
                                frun_reg[c] <= 1'b0;
                            end
                        end else begin
                            fcnt_reg[c] <= fcnt_reg[c] + 13'h0001;
                        end
                    end
                end
            end
        end
    endgenerate

    // Toggle matching per output
    genvar o, t;
    generate
        for (o = 0; o < OUTPUTS; o = o + 1) begin : g_out
            wire [2:0]       proto;
            wire [VAL_W-1:0] field_now;
            wire [TOGGLES-1:0] tog_hit;
            wire [TOGGLES-1:0] tog_f1;
            wire             counter_mode;
            wire             one_shot_mode;

            assign proto         = proto_of(output_protocol_select_reg, o);
            assign counter_mode  = proto == `FSOT_PROTO_FIRST || proto == `FSOT_PROTO_SECOND;
            assign one_shot_mode = proto == `FSOT_PROTO_ONE_SHOT;
            // Counter chosen by protocol code
            assign field_now     = (proto == `FSOT_PROTO_SECOND) ? fcnt_reg[1] : fcnt_reg[0];

            for (t = 0; t < TOGGLES; t = t + 1) begin : g_tog
                localparam integer BASE = o * 6 + (t / 2) * 3;
                localparam integer LANE = (t % 2) * VAL_W;
                wire [VAL_W-1:0] fd;
                wire [VAL_W-1:0] ln;
                wire [VAL_W-1:0] px;
                wire             fmatch;

                // Field, line and pixel words of this toggle
                assign fd = pos_words[BASE*POS_W + LANE +: VAL_W];
                assign ln = pos_words[(BASE+1)*POS_W + LANE +: VAL_W];
                assign px = pos_words[(BASE+2)*POS_W + LANE +: VAL_W];
                // Field 0 marks an unused toggle
                assign fmatch = one_shot_mode ?
                                (fd == `FSOT_ONE_SHOT_FIELD && one_shot_active_reg[o]) :
                                (counter_mode && fd != 13'h0000 && fd == field_now);
                assign tog_hit[t] = fmatch && ln == line_cnt_reg && px == pixel_cnt_reg;
                assign tog_f1[t]  = fd == 13'h0001;
            end

            // Without a field-1 toggle the counter pattern is dropped
            assign hit[o] = (|tog_hit) && (!counter_mode || (|tog_f1));

            always @(posedge clk_sys_i) begin
                if (reset_i) begin
                    aux_toggle_signal_reg[o] <= 1'b0;
                    one_shot_active_reg[o]   <= 1'b0;
                    one_shot_ready_reg[o]    <= 1'b0;
                end else begin
                    if (field_start) begin
                        // Active only in the field after the trigger
                        one_shot_active_reg[o] <= one_shot_mode &&
                            one_shot_field_trigger_reg[o] && one_shot_ready_reg[o];
                        // Protocol 1 arms only after a field at idle
                        if (proto == `FSOT_PROTO_IDLE) begin
                            one_shot_ready_reg[o] <= 1'b1;
                        end else if (!one_shot_mode) begin
                            one_shot_ready_reg[o] <= 1'b0;
                        end
                    end
                    case (proto)
                        `FSOT_PROTO_IDLE:    aux_toggle_signal_reg[o] <= polarity_reg[o];
                        `FSOT_PROTO_KEEP_ON: aux_toggle_signal_reg[o] <= 1'b1;
                        default: begin
                            if (hit[o]) begin
                                aux_toggle_signal_reg[o] <= ~aux_toggle_signal_reg[o];
                            end
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Pair tables; one per fixed pair
    genvar p;
    generate
        for (p = 0; p < OUTPUTS / 2; p = p + 1) begin : g_pair
            fsot_pair_lut u_pair_lut (
                .sig_lo_i  (aux_toggle_signal_reg[2*p]),
                .sig_hi_i  (aux_toggle_signal_reg[2*p+1]),
                .table_i   (lut_cfg_reg[`FSOT_TABLE_LSB + 4*p +: 4]),
                .use_lut_i (lut_cfg_reg[`FSOT_USE_LUT_LSB + 2*p +: 2]),
                .pin_lo_o  (pin_level[2*p]),
                .pin_hi_o  (pin_level[2*p+1])
            );
        end
    endgenerate

    // Pins registered so they never glitch on the table mux
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            aux_output_pin_o <= {OUTPUTS{1'b0}};
        end else begin
            aux_output_pin_o <= pin_level;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_rdata_o <= `FSOT_RST_WORD;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `FSOT_ADDR_LAUNCH:
                    reg_rdata_o <= {18'h00000, one_shot_field_trigger_reg, 4'h0, launch_reg};
                `FSOT_ADDR_FIELD_MAX:  reg_rdata_o <= field_max_reg;
                `FSOT_ADDR_FIELD_DLY:  reg_rdata_o <= field_dly_reg;
                `FSOT_ADDR_PROTOCOL:   reg_rdata_o <= {8'h00, output_protocol_select_reg};
                `FSOT_ADDR_COUNT_STAT: reg_rdata_o <= {4'h0, frun_reg, fcnt_reg[1], fcnt_reg[0]};
                `FSOT_ADDR_PIN_STAT:
                    reg_rdata_o <= {16'h0000, one_shot_active_reg, aux_toggle_signal_reg};
                `FSOT_ADDR_POLARITY:   reg_rdata_o <= {24'h000000, polarity_reg};
                `FSOT_ADDR_LUT_CFG:    reg_rdata_o <= {8'h00, lut_cfg_reg};
                default: begin
                    if (in_pos_window(reg_addr_i)) begin
                        reg_rdata_o <= {6'h00, pos_words[pos_index(reg_addr_i)*POS_W +: POS_W]};
                    end else begin
                        reg_rdata_o <= `FSOT_RST_WORD;
                    end
                end
            endcase
        end else begin
            reg_rdata_o <= `FSOT_RST_WORD;
        end
    end

endmodule // fsot_toggler
`default_nettype wire

// ==== hdl/fsot_map.vh ====
`ifndef FSOT_MAP_VH
`define FSOT_MAP_VH

// Register offsets
`define FSOT_ADDR_LAUNCH     8'h70
`define FSOT_ADDR_FIELD_MAX  8'h71
`define FSOT_ADDR_FIELD_DLY  8'h72
`define FSOT_ADDR_PROTOCOL   8'h73
`define FSOT_ADDR_COUNT_STAT 8'h75
`define FSOT_ADDR_PIN_STAT   8'h76
`define FSOT_ADDR_POLARITY   8'h7A
`define FSOT_ADDR_LUT_CFG    8'h7B
`define FSOT_ADDR_POS_FIRST  8'h7C
`define FSOT_ADDR_POS_LAST   8'hAB

// Field positions
`define FSOT_LAUNCH_FIRST    0
`define FSOT_LAUNCH_SECOND   1
`define FSOT_TRIG_LSB        6
`define FSOT_TRIG_MSB        13
`define FSOT_REPEAT_FIRST    26
`define FSOT_REPEAT_SECOND   27
`define FSOT_USE_LUT_LSB     0
`define FSOT_TABLE_LSB       8
`define FSOT_VAL_W           13
`define FSOT_POS_W           26

// Protocol codes
`define FSOT_PROTO_IDLE      3'h0
`define FSOT_PROTO_ONE_SHOT  3'h1
`define FSOT_PROTO_FIRST     3'h5
`define FSOT_PROTO_SECOND    3'h6
`define FSOT_PROTO_KEEP_ON   3'h7

// One-shot toggles always sit in field 1
`define FSOT_ONE_SHOT_FIELD  13'h0001

// Reset values
`define FSOT_RST_WORD        32'h00000000
`define FSOT_RST_POS         26'h0000000

// Example table codes
`define FSOT_TABLE_XOR       4'h6
`define FSOT_TABLE_NAND      4'h7
`define FSOT_TABLE_AND       4'h8
`define FSOT_TABLE_OR        4'hE

`endif

// ==== hdl/fsot_pos_mem.v ====
`timescale 1ns/1ps
`default_nettype none
`include "fsot_map.vh"

module fsot_pos_mem #(
    parameter WORDS = 48,
    parameter WIDTH = 26
) (
    // Clock and reset
    input  wire                   clk_sys_i,
    input  wire                   reset_i,
    // Write port
    input  wire                   wr_i,
    input  wire [5:0]             wr_idx_i,
    input  wire [WIDTH-1:0]       wr_data_i,
    // All words, held in flops
    output wire [WORDS*WIDTH-1:0] words_o
);

    reg [WIDTH-1:0] mem_reg [0:WORDS-1];

    genvar g;
    generate
        for (g = 0; g < WORDS; g = g + 1) begin : g_word
            // Writes never touch the toggle level logic directly
            always @(posedge clk_sys_i) begin
                if (reset_i) begin
                    mem_reg[g] <= `FSOT_RST_POS;
                end else if (wr_i && wr_idx_i == g) begin
                    mem_reg[g] <= wr_data_i;
                end
            end
            assign words_o[g*WIDTH +: WIDTH] = mem_reg[g];
        end
    endgenerate

endmodule // fsot_pos_mem
`default_nettype wire

// ==== hdl/fsot_pair_lut.v ====
`timescale 1ns/1ps
`default_nettype none
`include "fsot_map.vh"

module fsot_pair_lut (
    // Pair toggle signals
    input  wire       sig_lo_i,
    input  wire       sig_hi_i,
    // Configuration
    input  wire [3:0] table_i,
    input  wire [1:0] use_lut_i,
    // Pin levels for the pair
    output wire       pin_lo_o,
    output wire       pin_hi_o
);

    wire result;

    // Higher signal is the upper index bit
    assign result   = table_i[{sig_hi_i, sig_lo_i}];
    assign pin_lo_o = use_lut_i[0] ? result : sig_lo_i;
    assign pin_hi_o = use_lut_i[1] ? result : sig_hi_i;

endmodule // fsot_pair_lut
`default_nettype wire

// ==== bench/fsot_toggler_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsot_toggler_assertions #(
    parameter OUTPUTS = 8
) (
    // Clock and reset
    input wire logic               clk_sys_i,
    input wire logic               reset_i,
    // Register port
    input wire logic [7:0]         reg_addr_i,
    input wire logic [31:0]        reg_wdata_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [31:0]        reg_rdata_o,
    // Raster and pins
    input wire logic               field_sync_pulse_i,
    input wire logic               line_sync_pulse_i,
    input wire logic [OUTPUTS-1:0] aux_output_pin_o
);
    logic [23:0] proto_sh;
    logic [23:0] lut_sh;
    logic [7:0]  pol_sh;
    logic [1:0]  quiet;
    logic [7:0]  exp_pin;
    logic [31:0] rb_val;
    wire         cfg_hit = reg_addr_i == 8'h73 || reg_addr_i == 8'h7A || reg_addr_i == 8'h7B;
    wire         pos_hit = reg_addr_i >= 8'h7C && reg_addr_i <= 8'hAB;

    // Quiet counts cycles since the last setup write, so pins have settled
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            proto_sh <= 24'h000000;
            lut_sh <= 24'h000000;
            pol_sh <= 8'h00;
            quiet <= 2'h0;
        end else begin
            if (reg_wr_i && reg_addr_i == 8'h73) proto_sh <= reg_wdata_i[23:0];
            if (reg_wr_i && reg_addr_i == 8'h7B) lut_sh <= reg_wdata_i[23:0];
            if (reg_wr_i && reg_addr_i == 8'h7A) pol_sh <= reg_wdata_i[7:0];
            if (reg_wr_i && cfg_hit) quiet <= 2'h0;
            else if (quiet != 2'h3) quiet <= quiet + 2'h1;
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            exp_pin[i] = lut_sh[i] ? lut_sh[8 + 4 * (i / 2) + {pol_sh[i | 1], pol_sh[i & 6]}]
                                   : pol_sh[i];
        end
        rb_val = (reg_addr_i == 8'h73) ? {8'h00, proto_sh} :
                 (reg_addr_i == 8'h7A) ? {24'h000000, pol_sh} : {8'h00, lut_sh};
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    chk_idle_pin_map: assert property (
        quiet == 2'h3 && proto_sh == 24'h000000 |-> aux_output_pin_o == exp_pin)
        else $error("idle pin level differs from polarity and table");
    chk_launch_clear: assert property (
        $past(field_sync_pulse_i) && !$past(reg_wr_i) && reg_rd_i && reg_addr_i == 8'h70
        |=> {reg_rdata_o[13:6], reg_rdata_o[1:0]} == 10'h000)
        else $error("launch or trigger bits survive a field start");
    chk_status_pol: assert property (
        reg_rd_i && reg_addr_i == 8'h76 && quiet == 2'h3 && proto_sh == 24'h000000
        |=> reg_rdata_o[7:0] == $past(pol_sh))
        else $error("idle internal signals differ from polarity");
    chk_pos_write_calm: assert property (
        reg_wr_i && pos_hit && quiet == 2'h3 && proto_sh == 24'h000000
        |=> $stable(aux_output_pin_o) [*2])
        else $error("position write disturbed the pins");
    chk_cfg_readback: assert property (
        reg_rd_i && cfg_hit |=> reg_rdata_o == $past(rb_val))
        else $error("configuration readback wrong");
    chk_unmapped_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h74 |=> reg_rdata_o == 32'h00000000)
        else $error("unmapped read not zero");
    chk_rdata_idle: assert property (
        !reg_rd_i |=> reg_rdata_o == 32'h00000000)
        else $error("read data outside its cycle");
    chk_reset_clean: assert property (
        $fell(reset_i) |-> aux_output_pin_o == '0 && reg_rdata_o == 32'h00000000)
        else $error("outputs not cleared by reset");

    cover property (reg_wr_i && reg_addr_i == 8'h70);
    cover property (quiet == 2'h3 && proto_sh == 24'h000000 && lut_sh[7:0] != 8'h00);
    cover property ($changed(aux_output_pin_o) && proto_sh != 24'h000000);
endmodule // fsot_toggler_assertions
`default_nettype wire

// ==== bench/fsot_raster.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsot_raster #(
    parameter PIX   = 32,
    parameter LINES = 4
) (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // Timing to the toggler
    output wire logic       field_sync_pulse_o,
    output wire logic       line_sync_pulse_o,
    // Cycle within the field, for the bench
    output var  logic [7:0] pos_o
);
    // A short field keeps each scheduled scenario to a few hundred cycles
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || pos_o == 8'(PIX * LINES - 1)) pos_o <= 8'h00;
        else pos_o <= pos_o + 8'h01;
    end
    assign field_sync_pulse_o = !reset_i && pos_o == 8'h00;
    assign line_sync_pulse_o  = pos_o != 8'h00 && (pos_o % 8'(PIX)) == 8'h00;
endmodule // fsot_raster
`default_nettype wire

// ==== bench/fsot_toggler_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fsot_map.vh"
module fsot_toggler_test;
    localparam logic [7:0]  RST_A [5] = '{8'h70, 8'h73, 8'h74, 8'h7A, 8'h7B};
    localparam logic [3:0]  CODE [5] = '{`FSOT_TABLE_XOR, `FSOT_TABLE_NAND,
                                          `FSOT_TABLE_AND, `FSOT_TABLE_OR, 4'h2};
    // Last table is one-sided, so a swapped index order shows up
    localparam logic [3:0]  TRUTH [5] = '{4'h6, 4'h7, 4'h8, 4'hE, 4'h2};
    localparam logic [31:0] OS_POS [6] = '{32'h2001, 32'h4001, 32'h14005,
                                           32'h2001, 32'h6003, 32'h28005};
    localparam logic [7:0]  OS_AT [4] = '{8'h2A, 8'h50, 8'h6A, 8'h79};
    localparam logic [31:0] CT [3] = '{32'h4001, 32'h2001, 32'hA005};
    localparam logic [31:0] CT4 [3] = '{32'h0002, 32'h0001, 32'h0005};
    localparam logic [2:0]  CT_EXP [6] = '{3'h0, 3'h1, 3'h0, 3'h3, 3'h0, 3'h1};
    localparam logic [12:0] SEC [6] = '{13'h0, 13'h1, 13'h2, 13'h1, 13'h2, 13'h1};
    localparam logic [12:0] FIR [6] = '{13'h0, 13'h0, 13'h0, 13'h1, 13'h2, 13'h0};
    logic        clk_sys_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    wire  [31:0] reg_rdata_o;
    wire  [7:0]  aux_output_pin_o;
    wire         field_sync_pulse_i;
    wire         line_sync_pulse_i;
    wire  [7:0]  pos;
    int          failures = 0;
    int          tests_run = 0;
    logic [31:0] rdv;
    logic [7:0]  pv;
    logic [7:0]  ex;
    logic [1:0]  c2;
    logic        act;

    always #2.5 clk_sys_i = ~clk_sys_i;

    fsot_toggler uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .field_sync_pulse_i(field_sync_pulse_i),
        .line_sync_pulse_i(line_sync_pulse_i), .aux_output_pin_o(aux_output_pin_o));
    fsot_raster #(.PIX(32), .LINES(4)) far (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .field_sync_pulse_o(field_sync_pulse_i), .line_sync_pulse_o(line_sync_pulse_i),
        .pos_o(pos));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bus tasks are entered just after an edge and leave one edge spare
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        rdv = reg_rdata_o;
        @(posedge clk_sys_i);
    endtask
    // Returns at the edge that closes field cycle c
    task automatic at(input logic [7:0] c);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        while (pos !== c && n < 300) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 300) failures++;
    endtask
    task automatic give_verdict;
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        give_verdict;
    end

    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(RST_A[i]);
            check("reset word", rdv, 32'h0);
        end
        check("reset pins", 32'(aux_output_pin_o), 32'h0);
        // Lower pin of each pair through its table, upper pin raw
        for (int k = 0; k < 5; k++) begin
            for (int v = 0; v < 4; v++) begin
                wr(8'h7B, {8'h00, {4{CODE[k]}}, 8'h55});
                for (int p = 0; p < 4; p++) begin
                    c2 = 2'(v + p);
                    pv[2 * p +: 2] = c2;
                    ex[2 * p] = TRUTH[k][c2];
                    ex[2 * p + 1] = c2[1];
                end
                wr(8'h7A, {24'h0, pv});
                repeat (3) @(posedge clk_sys_i);
                check("pair pins", 32'(aux_output_pin_o), 32'(ex));
                rd(8'h76);
                check("idle signals", 32'(rdv[7:0]), 32'(pv));
            end
        end
        wr(8'h7B, 32'h0);
        wr(8'h7A, 32'h0);
        at(8'h00);
        for (int j = 0; j < 6; j++) wr(8'h7C + 8'(j), OS_POS[j]);
        rd(8'h81);
        check("position word", rdv, OS_POS[5]);
        wr(8'h73, 32'(`FSOT_PROTO_ONE_SHOT));
        // Trigger in fields 0 and 1: toggles in fields 1 and 2 only
        for (int f = 0; f < 4; f++) begin
            at(8'h00);
            rd(8'h70);
            check("trigger cleared", rdv, 32'h0);
            if (f < 2) wr(8'h70, 32'h40);
            act = (f == 1 || f == 2);
            for (int j = 0; j < 4; j++) begin
                at(OS_AT[j]);
                check("one-shot pin", 32'(aux_output_pin_o[0]), 32'(act & ~j[0]));
            end
        end
        wr(8'h7A, 32'h1);
        repeat (3) @(posedge clk_sys_i);
        check("held polarity", 32'(aux_output_pin_o[0]), 32'h0);
        wr(8'h73, 32'h0);
        repeat (3) @(posedge clk_sys_i);
        check("loaded polarity", 32'(aux_output_pin_o[0]), 32'h1);
        wr(8'h7A, 32'h0);
        // Out 2 second counter repeating, out 3 first counter delayed, out 4 lacks field 1
        for (int j = 0; j < 3; j++) begin
            wr(8'h82 + 8'(j), CT[j]);
            wr(8'h88 + 8'(j), CT[j]);
            wr(8'h8E + 8'(j), CT4[j]);
        end
        wr(8'h71, 32'h08004002);
        wr(8'h72, 32'h2);
        wr(8'h73, 32'hD70);
        for (int k = 0; k < 6; k++) begin
            at(8'h00);
            if (k == 0) wr(8'h70, 32'h3);
            rd(8'h75);
            check("counts", rdv, {4'h0, k ? {1'b1, k != 5} : 2'h0, SEC[k], FIR[k]});
            at(8'h2A);
            check("counter pins", 32'(aux_output_pin_o[3:1]), 32'(CT_EXP[k]));
        end
        wr(8'h73, 32'(`FSOT_PROTO_KEEP_ON));
        repeat (3) @(posedge clk_sys_i);
        check("keep on", 32'(aux_output_pin_o[0]), 32'h1);
        give_verdict;
    end
endmodule // fsot_toggler_test

bind fsot_toggler fsot_toggler_assertions #(.OUTPUTS(OUTPUTS)) chk (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .field_sync_pulse_i(field_sync_pulse_i), .line_sync_pulse_i(line_sync_pulse_i),
    .aux_output_pin_o(aux_output_pin_o));
`default_nettype wire
